// ===== bench/scd_osc_model.sv
`timescale 1ns/1ps

module scd_osc_model #(
    parameter int RC_HALF = 6,
    parameter int XTAL_HALF = 7,
    parameter int PLL_HALF = 5
) (
    // Core clock, and enables from the block
    input wire logic core_clk,
    input wire logic xtal_en,
    input wire logic rc_en,
    // Oscillator pins
    output logic rc_osc_hf,
    output logic crystal_osc_hf,
    output logic pll_clk
);
    int rc_cnt = 0;
    int xt_cnt = 0;
    int pl_cnt = 0;

    initial begin
        rc_osc_hf = 1'b0;
        crystal_osc_hf = 1'b0;
        pll_clk = 1'b0;
    end

    // ------
    // Sources
    // ------
    // enables honoured
    // A disabled source stands still, as the real one would
    always @(posedge core_clk) begin
        rc_cnt <= (rc_cnt + 1) % RC_HALF;
        xt_cnt <= (xt_cnt + 1) % XTAL_HALF;
        pl_cnt <= (pl_cnt + 1) % PLL_HALF;
        if (rc_en && rc_cnt == 0) begin
            rc_osc_hf <= ~rc_osc_hf;
        end
        if (xtal_en && xt_cnt == 0) begin
            crystal_osc_hf <= ~crystal_osc_hf;
        end
        if (pl_cnt == 0) begin
            pll_clk <= ~pll_clk;
        end
    end
endmodule : scd_osc_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "scd_consts.svh"

module testbench
    import scd_pkg::*;
;
    logic core_clk;
    logic rstn;
    scd_apb_req_s apb_req;
    scd_apb_rsp_s apb_rsp;
    logic rc_osc_hf, crystal_osc_hf, pll_clk, lp_mode, sleep_req;
    logic ebi_busy, trace_busy, trace_cfg_wr;
    scd_trace_cfg_s trace_cfg_in;
    scd_clk_out_s clk_out;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int tests_run = 0;
    int hi, lo, sh;
    int src_half [3] = '{6, 7, 5};

    scd_clock_ctrl DUT (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rc_osc_hf(rc_osc_hf), .crystal_osc_hf(crystal_osc_hf),
        .pll_clk(pll_clk), .lp_mode(lp_mode), .sleep_req(sleep_req), .ebi_busy(ebi_busy),
        .trace_busy(trace_busy), .trace_cfg_wr(trace_cfg_wr), .trace_cfg_in(trace_cfg_in),
        .clk_out(clk_out));

    scd_osc_model osc (.core_clk(core_clk), .xtal_en(clk_out.xtal_en), .rc_en(clk_out.rc_en),
        .rc_osc_hf(rc_osc_hf), .crystal_osc_hf(crystal_osc_hf), .pll_clk(pll_clk));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------
    // Helpers
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        check(n < 50, 32'h1);
    endtask : apb

    task automatic wsys(input logic [1:0] src, input logic [1:0] sd, input logic [13:0] gf,
        input logic [1:0] flags);
        apb(1'b1, `SCD_OFS_SYS, {12'h000, flags, gf, sd, src});
    endtask : wsys

    task automatic trace_cfg(input logic [1:0] div, input logic en, input logic gate);
        @(posedge core_clk);
        trace_cfg_wr <= 1'b1;
        trace_cfg_in <= '{div: div, en: en, idle_gate: gate};
        @(posedge core_clk);
        trace_cfg_wr <= 1'b0;
    endtask : trace_cfg

    function automatic logic sig(input int idx);
        case (idx)
            0: return clk_out.sys;
            1: return clk_out.ext_bus;
            2: return clk_out.trace;
            default: return clk_out.grp[idx-3];
        endcase
    endfunction : sig

    // Skips one full period so a clock still settling after a change is not judged
    task automatic chk_clk(input int idx, input int h, input int l);
        int n;
        int rises;
        logic prev;
        logic cur;
        n = 0;
        rises = 0;
        hi = 0;
        lo = 0;
        prev = 1'b1;
        while (rises < 3 && n < 8000) begin
            @(posedge core_clk);
            #1;
            cur = sig(idx);
            if (cur === 1'b1 && prev !== 1'b1) begin
                rises++;
            end
            if (rises == 2) begin
                if (cur === 1'b1) hi++;
                else lo++;
            end
            prev = cur;
            n++;
        end
        check(hi, h);
        check(lo, l);
    endtask : chk_clk

    task automatic quiet(input int idx);
        hi = 0;
        // Long enough for a divide-by-4 bus clock to finish its high phase
        repeat (40) @(posedge core_clk);
        repeat (80) begin
            @(posedge core_clk);
            #1;
            if (sig(idx) !== 1'b0) hi++;
        end
    endtask : quiet

    task automatic print_verdict();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // ------
    // Sequence
    // ------
    initial begin
        logic [13:0] gf;
        apb_req = '0;
        rstn = 1'b0;
        {lp_mode, sleep_req, ebi_busy, trace_busy, trace_cfg_wr} = 5'h00;
        trace_cfg_in = '0;
        void'($urandom(32'h6977));
        repeat (3) @(posedge core_clk);
        check(clk_out.xtal_en, 32'h1);
        check(clk_out.rc_en, 32'h1);
        rstn <= 1'b1;
        apb(1'b0, `SCD_OFS_SYS, 32'h0);
        check(rd, 32'h0004_0000);
        apb(1'b0, `SCD_OFS_EXT, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, `SCD_OFS_STAT, 32'h0);
        check(rd[10:0], 32'h300);
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0);
        check(err, 32'h1);
        apb(1'b1, `SCD_OFS_STAT, 32'hFFFF_FFFF);
        check(err, 32'h1);
        apb(1'b0, `SCD_OFS_STAT, 32'h0);
        check(rd[10:7], 32'h6);
        ebi_busy <= 1'b1;
        trace_busy <= 1'b1;
        sh = src_half[0];
        chk_clk(0, sh, sh);
        chk_clk(1, 2 * sh, 2 * sh);
        chk_clk(2, 2 * sh, 2 * sh);
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, `SCD_OFS_EXT, e);
            chk_clk(1, sh << (e - e / 3), sh << (e - e / 3));
        end
        for (int d = 0; d < 4; d++) begin
            trace_cfg(d[1:0], 1'b1, 1'b0);
            chk_clk(2, sh << d, sh << d);
        end
        ebi_busy <= 1'b0;
        quiet(1);
        check(hi, 0);
        trace_cfg(2'h0, 1'b0, 1'b0);
        quiet(2);
        check(hi, 0);
        trace_cfg(2'h0, 1'b1, 1'b1);
        trace_busy <= 1'b0;
        quiet(2);
        check(hi, 0);
        for (int k = 0; k < 7; k++) gf[2*k +: 2] = 2'(k % 4);
        // no peripheral runs on a group while its divide changes
        wsys(2'h0, 2'h0, gf, 2'h1);
        for (int k = 0; k < 7; k++) begin
            chk_clk(3 + k, sh, sh * ((2 << (k % 4)) - 1));
        end
        for (int i = 0; i < 4; i++) begin
            int s;
            int d;
            int g;
            s = $urandom % 3;
            d = $urandom % 4;
            g = $urandom % 7;
            gf = 14'($urandom);
            // no peripheral runs on a group while its divide changes
            wsys(s[1:0], d[1:0], gf, 2'h1);
            sh = src_half[s] << d;
            chk_clk(0, sh, sh);
            chk_clk(3 + g, sh, sh * ((2 << gf[2*g +: 2]) - 1));
            apb(1'b0, `SCD_OFS_STAT, 32'h0);
            check(rd[4:0], {d[1:0], s[1:0]});
        end
        wsys(2'h2, 2'h0, 14'h0, 2'h1);
        lp_mode <= 1'b1;
        repeat (40) @(posedge core_clk);
        apb(1'b0, `SCD_OFS_STAT, 32'h0);
        check({rd[5], rd[1:0]}, 32'h4);
        check(clk_out.xtal_en, 32'h0);
        chk_clk(0, src_half[0], src_half[0]);
        lp_mode <= 1'b0;
        wsys(2'h1, 2'h0, 14'h0, 2'h3);
        sleep_req <= 1'b1;
        repeat (40) @(posedge core_clk);
        check(clk_out.rc_en, 32'h0);
        sleep_req <= 1'b0;
        wsys(2'h0, 2'h0, 14'h0, 2'h1);
        chk_clk(0, src_half[0], src_half[0]);
        wsys(2'h0, 2'h0, 14'h0, 2'h0);
        repeat (3) @(posedge core_clk);
        check(clk_out.xtal_en, 32'h0);
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : testbench

// ===== inc/scd_consts.svh
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCD_OFS_SYS 8'h00
`define SCD_OFS_EXT 8'h04
`define SCD_OFS_STAT 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCD_SRC_LSB 0
`define SCD_DIV_LSB 2
`define SCD_GRP_LSB 4
`define SCD_XEN_BIT 18
`define SCD_RCOFF_BIT 19

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define SCD_EXT_DIV_RST 2'h1
`define SCD_TRC_DIV_RST 2'h1
`define SCD_NGRP 7
`define SCD_NPIN 5

`endif

// ===== inc/scd_pkg.sv
package scd_pkg;

`include "scd_consts.svh"

typedef enum logic [1:0] {
    SCD_SRC_RC,
    SCD_SRC_XTAL,
    SCD_SRC_PLL
} scd_src_e;

typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
} scd_apb_req_s;

typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} scd_apb_rsp_s;

typedef struct packed {
    logic [1:0] div;
    logic en;
    logic idle_gate;
} scd_trace_cfg_s;

typedef struct packed {
    logic sys;
    logic ext_bus;
    logic trace;
    logic [`SCD_NGRP-1:0] grp;
    logic xtal_en;
    logic rc_en;
} scd_clk_out_s;

typedef struct packed {
    logic [`SCD_NPIN-1:0][2:0] sync;
    logic [`SCD_NPIN-1:0] pin;
    logic [1:0] src_sel;
    logic [1:0] sys_div;
    logic [`SCD_NGRP-1:0][1:0] grp_div;
    logic xtal_en;
    logic rc_off;
    logic [1:0] ext_div;
    scd_trace_cfg_s trc;
    scd_src_e act_src;
    logic [1:0] act_div;
    logic pend;
    logic [2:0] sys_cnt;
    logic sys_clk;
    logic sys_rise;
    logic sys_fall;
    logic [2:0] ext_cnt;
    logic ext_clk;
    logic [2:0] trc_cnt;
    logic trc_clk;
    logic [2:0] tap_cnt;
    logic [`SCD_NGRP-1:0] grp_clk;
    logic xtal_on;
    logic rc_on;
    scd_apb_rsp_s rsp;
} scd_state_s;

endpackage : scd_pkg

// ===== src/scd_clock_ctrl.sv
// Functional notes
// [R1] After reset the system clock runs from the 16 MHz RC oscillator.
// [R2] Source select picks RC oscillator, crystal oscillator or PLL.
// [R3] Selected source divided by 1, 2, 4 or 8 forms system clock.
// [R4] External bus clock is system clock divided by 1, 2 or 4.
// [R5] External bus divide resets to half the system clock.
// [R6] External bus clock may stop while no bus access runs.
// [R7] External bus clock has equal high and low times.
// [R8] Trace clock is system clock divided by 1, 2, 4 or 8.
// [R9] Trace clock divide resets to half the system clock.
// [R10] Trace divide field is written only through the debug port path.
// [R11] Clearing trace clock enable stops the trace clock.
// [R12] Idle gate stops trace clock while no trace message is sent.
// [R13] Trace clock has equal high and low times.
// [R14] Each peripheral group has its own independent divide 1, 2, 4, 8.
// [R15] Seven peripheral groups 0 to 6; group 7 reserved.
// [R16] Shared divider taps; group clock is half-system-period high pulse.
// [R17] Unused high-order taps of the shared divider are switched off.
// [R18] Software disables affected peripherals before changing group divide.
// [R19] Divided groups take proportionally more system cycles per access.
// [R20] Low-power mode forbids PLL and crystal; source falls back to RC.
// [R21] Crystal enabled after reset, software may disable; RC stays on. (Code stops RC in sleep when rc_off is set and RC is not the active source.)
// [R22] Source or divide switching is glitch-free.
`timescale 1ns/1ps

module scd_clock_ctrl
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register bus
    input wire scd_apb_req_s apb_req,
    output scd_apb_rsp_s apb_rsp,
    // Oscillator and mode pins
    input wire logic rc_osc_hf,
    input wire logic crystal_osc_hf,
    input wire logic pll_clk,
    input wire logic lp_mode,
    input wire logic sleep_req,
    // Activity from bus and trace logic
    input wire logic ebi_busy,
    input wire logic trace_busy,
    // Trace port controller write path
    input wire logic trace_cfg_wr,
    input wire scd_trace_cfg_s trace_cfg_in,
    // Clock outputs and oscillator enables
    output scd_clk_out_s clk_out
);

    localparam scd_state_s ST_RST = '{
        default: '0,
        xtal_en: 1'b1,
        ext_div: `SCD_EXT_DIV_RST,
        trc: '{div: `SCD_TRC_DIV_RST, en: 1'b1, idle_gate: 1'b0},
        act_src: SCD_SRC_RC,
        xtal_on: 1'b1,
        rc_on: 1'b1
    };

    scd_state_s st_reg;
    scd_state_s st_next;
    logic [`SCD_NPIN-1:0] pins;
    logic [`SCD_NPIN-1:0] pin_edge;
    logic src_edge;
    logic sys_tog;
    logic setup;
    logic acc;
    scd_src_e req_src;
    logic [1:0] max_div;
    logic [1:0] ext_d;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] dmask(input logic [1:0] d);
        return 3'((4'h1 << d) - 4'h1);
    endfunction : dmask

    function automatic logic last(input logic [2:0] c, input logic [1:0] d);
        return c == dmask(d);
    endfunction : last

    assign pins = {sleep_req, lp_mode, pll_clk, crystal_osc_hf, rc_osc_hf};
    assign apb_rsp = st_reg.rsp;
    assign clk_out = {st_reg.sys_clk, st_reg.ext_clk, st_reg.trc_clk,
        st_reg.grp_clk, st_reg.xtal_on, st_reg.rc_on};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        pin_edge = '0;
        src_edge = 1'b0;
        sys_tog = 1'b0;
        req_src = SCD_SRC_RC;
        max_div = 2'h0;
        ext_d = 2'h0;
        setup = apb_req.psel && !apb_req.penable;
        acc = apb_req.psel && apb_req.penable && st_reg.rsp.pready;

        // Pins count a change once the second and third stages agree
        for (int i = 0; i < `SCD_NPIN; i++) begin
            st_next.sync[i] = {st_reg.sync[i][1:0], pins[i]};
            if (st_reg.sync[i][1] == st_reg.sync[i][2]) begin
                st_next.pin[i] = st_reg.sync[i][2];
            end
        end
        pin_edge = st_next.pin ^ st_reg.pin;
        src_edge = pin_edge[st_reg.act_src];

        // [R20] low-power fallback
        if (st_reg.pin[3]) begin
            req_src = SCD_SRC_RC;
        end else begin
            // [R2] source choice
            unique case (st_reg.src_sel)
                2'h1: req_src = SCD_SRC_XTAL;
                2'h2: req_src = SCD_SRC_PLL;
                default: req_src = SCD_SRC_RC;
            endcase
        end

        // [R3] count source half periods
        sys_tog = src_edge && last(st_reg.sys_cnt, st_reg.act_div);
        st_next.sys_rise = 1'b0;
        st_next.sys_fall = 1'b0;
        if (src_edge) begin
            st_next.sys_cnt = sys_tog ? 3'h0 : st_reg.sys_cnt + 3'h1;
        end
        if (sys_tog) begin
            st_next.sys_clk = !st_reg.sys_clk;
            st_next.sys_rise = !st_reg.sys_clk;
            st_next.sys_fall = st_reg.sys_clk;
        end

        // [R22] switch only in the low phase
        st_next.pend = (req_src != st_reg.act_src) || (st_reg.sys_div != st_reg.act_div);
        if (st_next.pend && !st_reg.sys_clk && !sys_tog) begin
            // Low phase restarts on the new source, so it can only grow
            st_next.act_src = req_src;
            st_next.act_div = st_reg.sys_div;
            st_next.sys_cnt = 3'h0;
            st_next.pend = 1'b0;
        end

        // [R4] external bus divider, code 3 treated as divide by 4
        ext_d = (st_reg.ext_div == 2'h3) ? 2'h2 : st_reg.ext_div;
        // [R6] hold low while the bus is idle
        if (!st_reg.ext_clk && !ebi_busy) begin
            st_next.ext_cnt = 3'h0;
        end else if (st_reg.sys_rise || st_reg.sys_fall) begin
            // [R7] toggle every divide system half periods
            if (last(st_reg.ext_cnt, ext_d)) begin
                st_next.ext_cnt = 3'h0;
                st_next.ext_clk = !st_reg.ext_clk;
            end else begin
                st_next.ext_cnt = st_reg.ext_cnt + 3'h1;
            end
        end

        // [R11] trace clock fully off
        if (!st_reg.trc.en) begin
            st_next.trc_cnt = 3'h0;
            st_next.trc_clk = 1'b0;
        end else if (st_reg.trc.idle_gate && !trace_busy && !st_reg.trc_clk) begin
            // [R12] idle gating
            st_next.trc_cnt = 3'h0;
        end else if (st_reg.sys_rise || st_reg.sys_fall) begin
            // [R8] [R13] symmetric trace divider
            if (last(st_reg.trc_cnt, st_reg.trc.div)) begin
                st_next.trc_cnt = 3'h0;
                st_next.trc_clk = !st_reg.trc_clk;
            end else begin
                st_next.trc_cnt = st_reg.trc_cnt + 3'h1;
            end
        end

        // [R17] only the taps some group uses keep counting
        for (int k = 0; k < `SCD_NGRP; k++) begin
            if (st_reg.grp_div[k] > max_div) begin
                max_div = st_reg.grp_div[k];
            end
        end
        st_next.tap_cnt = (st_reg.sys_rise ? st_reg.tap_cnt + 3'h1 : st_reg.tap_cnt)
            & dmask(max_div);
        // [R16] one shared divider, group pulses high for half a period
        if (st_reg.sys_rise) begin
            for (int k = 0; k < `SCD_NGRP; k++) begin
                // [R14] [R19] per-group tap choice slows the group
                st_next.grp_clk[k] = (st_reg.tap_cnt & dmask(st_reg.grp_div[k])) == 3'h0;
            end
        end else if (st_reg.sys_fall) begin
            st_next.grp_clk = '0;
        end

        // [R21] oscillator enables
        st_next.xtal_on = st_reg.xtal_en && !st_reg.pin[3];
        st_next.rc_on = !(st_reg.pin[4] && st_reg.rc_off && st_reg.act_src != SCD_SRC_RC);

        // [R10] trace settings only from the debug path
        if (trace_cfg_wr) begin
            st_next.trc = trace_cfg_in;
        end

        // ----------------------------------------
        // Register bus, one wait-free access phase
        // ----------------------------------------
        st_next.rsp.pready = setup;
        if (setup) begin
            st_next.rsp.pslverr = 1'b0;
            st_next.rsp.prdata = '0;
            case (apb_req.paddr)
                `SCD_OFS_SYS: begin
                    st_next.rsp.prdata = {12'h000, st_reg.rc_off, st_reg.xtal_en,
                        st_reg.grp_div, st_reg.sys_div, st_reg.src_sel};
                end
                `SCD_OFS_EXT: begin
                    st_next.rsp.prdata = {30'h0, st_reg.ext_div};
                end
                `SCD_OFS_STAT: begin
                    st_next.rsp.pslverr = apb_req.pwrite;
                    st_next.rsp.prdata = {21'h0, st_reg.trc, st_reg.pin[4],
                        st_reg.pin[3], st_reg.pend, st_reg.act_div, st_reg.act_src};
                end
                default: begin
                    st_next.rsp.pslverr = 1'b1;
                end
            endcase
        end
        if (acc && apb_req.pwrite && !st_reg.rsp.pslverr) begin
            if (apb_req.paddr == `SCD_OFS_SYS) begin
                // [R2] [R3] [R14] [R15] software selection fields
                st_next.src_sel = apb_req.pwdata[`SCD_SRC_LSB +: 2];
                st_next.sys_div = apb_req.pwdata[`SCD_DIV_LSB +: 2];
                st_next.grp_div = apb_req.pwdata[`SCD_GRP_LSB +: 2 * `SCD_NGRP];
                st_next.xtal_en = apb_req.pwdata[`SCD_XEN_BIT];
                st_next.rc_off = apb_req.pwdata[`SCD_RCOFF_BIT];
            end else if (apb_req.paddr == `SCD_OFS_EXT) begin
                st_next.ext_div = apb_req.pwdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // [R1] [R5] [R9] reset values
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence

    sequence s_sys_wr;
        acc && apb_req.pwrite && apb_req.paddr == `SCD_OFS_SYS && !st_reg.rsp.pslverr;
    endsequence

    AST_APB_WRITE: assert property (s_sys_wr |=> // [R2]
        st_reg.src_sel == $past(apb_req.pwdata[1:0]))
    else $error("source select not written");

    AST_APB_READY: assert property (s_setup |=> st_reg.rsp.pready ##1 !st_reg.rsp.pready)
    else $error("ready not a single cycle");

    AST_LP_FALLBACK: assert property (st_reg.pin[3] && !st_reg.sys_clk && !sys_tog // [R20]
        |=> st_reg.act_src == SCD_SRC_RC)
    else $error("low power kept a fast source");

    AST_SYS_EDGE: assert property ($changed(st_reg.sys_clk) |-> $past(src_edge)) // [R3]
    else $error("system clock moved without source edge");

    AST_SWITCH_LOW: assert property ($changed(st_reg.act_src) || $changed(st_reg.act_div) // [R22]
        |-> !$past(st_reg.sys_clk) && !st_reg.sys_clk)
    else $error("switch while clock high");

    AST_EXT_GATE: assert property (!st_reg.ext_clk && !ebi_busy |=> !st_reg.ext_clk) // [R6]
    else $error("bus clock ran while idle");

    AST_TRC_OFF: assert property (!st_reg.trc.en |=> !st_reg.trc_clk) // [R11]
    else $error("trace clock ran while disabled");

    AST_TRC_GATE: assert property (st_reg.trc.en && st_reg.trc.idle_gate // [R12]
        && !trace_busy && !st_reg.trc_clk |=> !st_reg.trc_clk)
    else $error("trace clock ran while idle");

    AST_TAP_OFF: assert property (st_reg.grp_div == '0 |=> st_reg.tap_cnt == 3'h0) // [R17]
    else $error("unused tap kept counting");

    AST_GRP_PULSE: assert property ($rose(st_reg.grp_clk[0]) // [R16]
        |-> $past(st_reg.sys_rise) && st_reg.sys_clk)
    else $error("group pulse outside high phase");

    // ----------------------------------------
    // Divider, filter, enable and trace settings assertions
    // ----------------------------------------
    // A pin level moves only once the last two filter stages agree
    AST_PIN_FILTER: assert property ($changed(st_reg.pin[0]) // [R3]
        |-> $past(st_reg.sync[0][1]) == $past(st_reg.sync[0][2]))
    else $error("source pin passed the filter early");

    AST_SYS_CNT: assert property (st_reg.sys_cnt <= dmask(st_reg.act_div)) // [R3]
    else $error("system divide counter out of range");

    // Output dividers step only on system half periods, which keeps them symmetric
    AST_EXT_STEP: assert property ($changed(st_reg.ext_clk) // [R7]
        |-> $past(st_reg.sys_rise || st_reg.sys_fall))
    else $error("bus clock moved between system half periods");

    AST_TRC_STEP: assert property ($changed(st_reg.trc_clk) && $past(st_reg.trc.en) // [R13]
        |-> $past(st_reg.sys_rise || st_reg.sys_fall))
    else $error("trace clock moved between system half periods");

    AST_GRP_END: assert property (st_reg.sys_fall |=> st_reg.grp_clk == '0) // [R16]
    else $error("group pulse outlived the high phase");

    AST_XTAL_LP: assert property (st_reg.pin[3] |=> !st_reg.xtal_on) // [R20]
    else $error("crystal kept running in low power");

    // RC may only stop once another source drives the system clock
    AST_RC_KEPT: assert property (st_reg.act_src == SCD_SRC_RC |=> st_reg.rc_on) // [R21]
    else $error("RC oscillator stopped while driving the system clock");

    AST_TRC_LOAD: assert property (trace_cfg_wr |=> st_reg.trc == $past(trace_cfg_in)) // [R10]
    else $error("trace settings not taken from the debug path");

    // Status is read-only, so trace settings cannot arrive over the register bus
    AST_STAT_RO: assert property (s_setup ##0 (apb_req.pwrite // [R10]
        && apb_req.paddr == `SCD_OFS_STAT) |=> st_reg.rsp.pslverr)
    else $error("status write not refused");

endmodule : scd_clock_ctrl
